// [hw/rx_timeout_timer.sv]
`timescale 1ns/1ps
`default_nettype none

module rx_timeout_timer
	import uart_irq_pkg::*;
#(
	parameter int CNT_W = 7
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       bit_tick,
	input  wire logic       run,
	input  wire logic       restart,
	input  wire logic [3:0] char_bits,
	output logic            expired
);

	// Longest limit is four 15-bit characters plus twelve bits
	if (CNT_W < 7) begin : g_chk
		$error("rx_timeout_timer: CNT_W too small");
	end

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             expired;
	} tmr_state_t;

	tmr_state_t st_r;
	tmr_state_t st_nxt;
	logic [CNT_W-1:0] limit;

	// Four character times plus twelve bit times, in bit ticks
	assign limit = CNT_W'(TIMEOUT_CHARS * char_bits) + CNT_W'(TIMEOUT_BITS);

	// Counts only while data waits; a data register read or new character restarts it
	always_comb begin
		st_nxt = st_r;
		if (restart || !run) begin
			st_nxt.cnt     = '0;
			st_nxt.expired = 1'b0;
		end else if (bit_tick && !st_r.expired) begin
			if (st_r.cnt + CNT_W'(1) >= limit) begin
				st_nxt.expired = 1'b1;
			end
			st_nxt.cnt = st_r.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign expired = st_r.expired;

endmodule : rx_timeout_timer

`default_nettype wire

// [hw/uart_interrupt_fifo_control.sv]
// Function
// - Receive interrupt tracks FIFO count versus trigger
// - Data-ready flag set on load, cleared when empty
// - Enables all clear gives polled mode, status live
// - Status top bits: FIFO error, transmitter idle
// - Receive enable: holding data or trigger level
// - Transmit enable: empty edge or already empty
// - Overrun immediate; head-character errors interrupt too
// - Any modem change flag requests interrupt
// - Enable upper nibble reads zero, resets zero
// - Status read reports only highest pending source
// - Source codes 0110,1100,0100,0010,0000,none 0001
// - Timeout after four characters plus twelve bits
// - Transmit source: holding or FIFO empty
// - Line, modem reads clear; transmit by status/write
// - Timeout clears on data read; trigger below level
// - Status bit zero low while pending, resets one
// - Status top bits show FIFO enable, 5:4 zero
// - FIFO enable must accompany other control bits
// - Receive FIFO reset pulse, self-clearing
// - Transmit FIFO reset pulse, self-clearing
// - DMA select changes ready pin behaviour
// - Trigger codes select 1, 4, 8, 14
`timescale 1ns/1ps
`default_nettype none

module uart_interrupt_fifo_control
	import uart_irq_pkg::*;
#(
	parameter int FIFO_DEPTH = 16,
	parameter int CNT_W      = 5
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	// Host register port
	input  wire logic [2:0]       addr,
	input  wire logic             rd_en,
	input  wire logic             wr_en,
	input  wire logic [7:0]       wr_data,
	output logic      [7:0]       rd_data,
	input  wire logic             divisor_sel,
	// Receive path status
	input  wire logic [CNT_W-1:0] rx_fifo_count,
	input  wire logic             rx_char_loaded,
	input  wire logic             rx_overrun_evt,
	input  wire logic [2:0]       rx_head_error,
	input  wire logic             rx_fifo_any_error,
	input  wire logic             rx_bit_tick,
	input  wire logic [3:0]       char_bits,
	// Transmit path status
	input  wire logic             tx_holding_empty,
	input  wire logic             tx_all_empty,
	input  wire logic             tx_fifo_full,
	// Modem lines and change events
	input  wire logic [3:0]       modem_lines,
	input  wire logic [3:0]       modem_change,
	// Control outputs
	output logic                  fifo_enabled,
	output logic                  dma_mode,
	output logic [4:0]            rx_trigger_level,
	output logic                  rx_fifo_reset,
	output logic                  tx_fifo_reset,
	output logic                  receive_ready_pin_n,
	output logic                  transmit_ready_pin_n,
	output logic                  irq
);

	// The deepest trigger must fit the FIFO, and a full FIFO must fit the count
	if (FIFO_DEPTH < int'(TRIG_LVL3) || FIFO_DEPTH >= (1 << CNT_W)) begin : g_chk
		$error("uart_interrupt_fifo_control: FIFO_DEPTH or CNT_W unusable");
	end

	// Timeout counter width: four 15-bit characters plus twelve bits stay below 128
	localparam int TMR_W = 7;

	// All control and interrupt state except the timeout timer, registered as one word
	typedef struct packed {
		logic [3:0] ie;
		logic       fifo_en;
		logic       dma;
		logic [1:0] trig;
		logic       rx_rst;
		logic       tx_rst;
		logic       overrun;
		logic       ls_irq;
		logic       err_seen;
		logic       tx_irq;
		logic       thr_empty_d;
		logic [3:0] delta;
		logic [7:0] rd_data;
		logic       receive_ready_pin_n_n;
		logic       transmit_ready_pin_n_n;
	} ctl_state_t;

	ctl_state_t st_r;
	ctl_state_t st_nxt;

	logic       data_ready;
	logic [4:0] trig_lvl;
	logic       at_trigger;
	logic       rx_src;
	logic       to_src;
	logic       to_expired;
	logic       ls_src;
	logic       tx_src;
	logic       ms_src;
	src_t       src;
	logic [3:0] src_code;
	logic [7:0] ie_val;
	logic [7:0] is_val;
	logic [7:0] ls_val;
	logic [7:0] ms_val;
	logic       rd_data_hit;
	logic       rd_is_hit;
	logic       rd_ls_hit;
	logic       rd_ms_hit;
	logic       wr_thr_hit;
	logic       wr_ie_hit;
	logic       wr_fc_hit;
	logic [CNT_W-1:0] trig_cmp;
	logic             tmr_run;
	logic             tmr_restart;

	// Divisor latch selection hides the data and enable registers
	assign rd_data_hit = rd_en && addr == ADDR_DATA && !divisor_sel;
	assign wr_thr_hit  = wr_en && addr == ADDR_DATA && !divisor_sel;
	assign wr_ie_hit   = wr_en && addr == ADDR_IE && !divisor_sel;
	assign rd_is_hit   = rd_en && addr == ADDR_IS;
	assign wr_fc_hit   = wr_en && addr == ADDR_IS;
	assign rd_ls_hit   = rd_en && addr == ADDR_LS;
	assign rd_ms_hit   = rd_en && addr == ADDR_MS;

	// Count is the truth for data ready, so it can only drop once empty
	assign data_ready = rx_fifo_count != '0;

	// Trigger level decode
	always_comb begin
		case (st_r.trig)
			2'b00:   trig_lvl = TRIG_LVL0;
			2'b01:   trig_lvl = TRIG_LVL1;
			2'b10:   trig_lvl = TRIG_LVL2;
			2'b11:   trig_lvl = TRIG_LVL3;
			default: trig_lvl = TRIG_LVL0;
		endcase
	end

	// Compare at the count's own width so a deeper FIFO is never cut short
	assign trig_cmp = CNT_W'(trig_lvl);

	// Without FIFOs one character in the holding register is enough
	assign at_trigger = st_r.fifo_en ? (rx_fifo_count >= trig_cmp)
	                                 : data_ready;

	// Timer runs on bit ticks while characters wait uncollected, FIFO mode only
	assign tmr_run     = st_r.fifo_en && data_ready;
	assign tmr_restart = rd_data_hit || rx_char_loaded;

	rx_timeout_timer #(
		.CNT_W(TMR_W)
	) u_timeout (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.bit_tick (rx_bit_tick),
		.run      (tmr_run),
		.restart  (tmr_restart),
		.char_bits(char_bits),
		.expired  (to_expired)
	);

	// Source levels, each gated by its enable; all enables low means polled
	assign ls_src = st_r.ie[IE_LS] && st_r.ls_irq;
	assign to_src = st_r.ie[IE_RX] && to_expired;
	assign rx_src = st_r.ie[IE_RX] && at_trigger;
	assign tx_src = st_r.ie[IE_TX] && st_r.tx_irq;
	assign ms_src = st_r.ie[IE_MS] && (st_r.delta != 4'h0);

	// Fixed priority: only the top pending source is ever reported
	always_comb begin
		if (ls_src) begin
			src = SRC_LS;
		end else if (to_src) begin
			src = SRC_TO;
		end else if (rx_src) begin
			src = SRC_RX;
		end else if (tx_src) begin
			src = SRC_TX;
		end else if (ms_src) begin
			src = SRC_MS;
		end else begin
			src = SRC_NONE;
		end
	end

	// Source encoding; bit zero is low whenever something is pending
	always_comb begin
		case (src)
			SRC_LS:   src_code = IS_LS;
			SRC_TO:   src_code = IS_TO;
			SRC_RX:   src_code = IS_RX;
			SRC_TX:   src_code = IS_TX;
			SRC_MS:   src_code = IS_MS;
			SRC_NONE: src_code = IS_NONE;
			default:  src_code = IS_NONE;
		endcase
	end

	// Readable images of the registers
	assign ie_val = {4'h0, st_r.ie};
	assign is_val = {{2{st_r.fifo_en}}, 2'b00, src_code};
	assign ls_val = {st_r.fifo_en && rx_fifo_any_error,
	                 tx_all_empty,
	                 tx_holding_empty,
	                 rx_head_error,
	                 st_r.overrun,
	                 data_ready};
	assign ms_val = {modem_lines, st_r.delta};

	// Register reads, writes and their side effects
	always_comb begin
		st_nxt = st_r;
		// Flush pulses last one cycle; a later write raises them again
		st_nxt.rx_rst      = 1'b0;
		st_nxt.tx_rst      = 1'b0;
		st_nxt.thr_empty_d = tx_holding_empty;

		// Read data is held until the next read
		if (rd_en) begin
			case (addr)
				ADDR_DATA: st_nxt.rd_data = 8'h00;
				ADDR_IE:   st_nxt.rd_data = divisor_sel ? 8'h00 : ie_val;
				ADDR_IS:   st_nxt.rd_data = is_val;
				ADDR_LS:   st_nxt.rd_data = ls_val;
				ADDR_MS:   st_nxt.rd_data = ms_val;
				default:   st_nxt.rd_data = 8'h00;
			endcase
		end

		// Enable write; the transmit interrupt fires at once if already empty
		// Rewriting an enable that is already set does not re-arm its source
		if (wr_ie_hit) begin
			st_nxt.ie = wr_data[3:0];
			if (wr_data[IE_TX] && !st_r.ie[IE_TX] && tx_holding_empty) begin
				st_nxt.tx_irq = 1'b1;
			end
		end

		// Control bits only take effect alongside the FIFO enable
		// A write with the enable low turns the FIFOs off and keeps the rest
		if (wr_fc_hit) begin
			st_nxt.fifo_en = wr_data[FC_EN];
			if (wr_data[FC_EN]) begin
				st_nxt.rx_rst = wr_data[FC_RXRST];
				st_nxt.tx_rst = wr_data[FC_TXRST];
				st_nxt.dma    = wr_data[FC_DMA];
				st_nxt.trig   = wr_data[FC_TRIG_H:FC_TRIG_L];
			end
		end

		// Transmit source clears on status read reporting it or a data write
		if ((rd_is_hit && src == SRC_TX) || wr_thr_hit) begin
			st_nxt.tx_irq = 1'b0;
		end
		// Setting wins over the clear so an empty edge is never lost
		if (tx_holding_empty && !st_r.thr_empty_d) begin
			st_nxt.tx_irq = 1'b1;
		end

		// Line status: overrun sticky, head errors seen once per character
		// An error seen while its enable is off stays pending until status is read
		if (rd_ls_hit) begin
			st_nxt.overrun = 1'b0;
			st_nxt.ls_irq  = 1'b0;
		end
		if (rd_data_hit || rx_head_error == 3'b000) begin
			st_nxt.err_seen = 1'b0;
		end
		if (rx_overrun_evt) begin
			st_nxt.overrun = 1'b1;
			st_nxt.ls_irq  = 1'b1;
		end
		if (rx_head_error != 3'b000 && !st_r.err_seen && !rd_data_hit) begin
			st_nxt.ls_irq   = 1'b1;
			st_nxt.err_seen = 1'b1;
		end

		// Modem change flags: cleared by read, new changes win
		if (rd_ms_hit) begin
			st_nxt.delta = 4'h0;
		end
		st_nxt.delta = st_nxt.delta | modem_change;

		// Ready pins, active low
		// Registered so the pins never glitch while the sources settle
		if (st_r.dma) begin
			// Block transfers: signal at trigger or timeout, room to write
			if (at_trigger || to_expired) begin
				st_nxt.receive_ready_pin_n_n = 1'b0;
			end else if (!data_ready) begin
				st_nxt.receive_ready_pin_n_n = 1'b1;
			end
			st_nxt.transmit_ready_pin_n_n = tx_fifo_full;
		end else begin
			// Single transfers: any data waiting, holding register empty
			st_nxt.receive_ready_pin_n_n = !data_ready;
			st_nxt.transmit_ready_pin_n_n = !tx_holding_empty;
		end
	end

	// Reset values spelled out field by field; otherwise follow st_nxt
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r.ie          <= IE_RESET;
			st_r.fifo_en     <= 1'b0;
			st_r.dma         <= 1'b0;
			st_r.trig        <= TRIG_RESET;
			st_r.rx_rst      <= 1'b0;
			st_r.tx_rst      <= 1'b0;
			st_r.overrun     <= 1'b0;
			st_r.ls_irq      <= 1'b0;
			st_r.err_seen    <= 1'b0;
			st_r.tx_irq      <= 1'b0;
			st_r.thr_empty_d <= 1'b1;
			st_r.delta       <= 4'h0;
			st_r.rd_data     <= 8'h00;
			st_r.receive_ready_pin_n_n     <= 1'b1;
			st_r.transmit_ready_pin_n_n     <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs
	assign rd_data              = st_r.rd_data;
	assign fifo_enabled         = st_r.fifo_en;
	assign dma_mode             = st_r.dma;
	assign rx_trigger_level     = trig_lvl;
	assign rx_fifo_reset        = st_r.rx_rst;
	assign tx_fifo_reset        = st_r.tx_rst;
	assign receive_ready_pin_n  = st_r.receive_ready_pin_n_n;
	assign transmit_ready_pin_n = st_r.transmit_ready_pin_n_n;
	// Level output that drops once the last enabled source is serviced
	assign irq                  = src != SRC_NONE;

endmodule : uart_interrupt_fifo_control

`default_nettype wire

// [hw/uart_irq_pkg.sv]
package uart_irq_pkg;

	// Register offsets on the three-bit channel address
	localparam logic [2:0] ADDR_DATA = 3'h0;
	localparam logic [2:0] ADDR_IE   = 3'h1;
	localparam logic [2:0] ADDR_IS   = 3'h2;
	localparam logic [2:0] ADDR_LS   = 3'h5;
	localparam logic [2:0] ADDR_MS   = 3'h6;

	// interrupt_enable bit positions
	localparam int IE_RX = 0;
	localparam int IE_TX = 1;
	localparam int IE_LS = 2;
	localparam int IE_MS = 3;

	// fifo_control bit positions
	localparam int FC_EN     = 0;
	localparam int FC_RXRST  = 1;
	localparam int FC_TXRST  = 2;
	localparam int FC_DMA    = 3;
	localparam int FC_TRIG_L = 6;
	localparam int FC_TRIG_H = 7;

	// Reset values
	localparam logic [3:0] IE_RESET   = 4'h0;
	localparam logic [1:0] TRIG_RESET = 2'h0;

	// interrupt_status source codes, low nibble
	localparam logic [3:0] IS_LS   = 4'h6;
	localparam logic [3:0] IS_TO   = 4'hC;
	localparam logic [3:0] IS_RX   = 4'h4;
	localparam logic [3:0] IS_TX   = 4'h2;
	localparam logic [3:0] IS_MS   = 4'h0;
	localparam logic [3:0] IS_NONE = 4'h1;

	// Receive trigger levels for codes 00, 01, 10, 11
	localparam logic [4:0] TRIG_LVL0 = 5'h01;
	localparam logic [4:0] TRIG_LVL1 = 5'h04;
	localparam logic [4:0] TRIG_LVL2 = 5'h08;
	localparam logic [4:0] TRIG_LVL3 = 5'h0E;

	// Receive timeout: characters plus extra bit times
	localparam int TIMEOUT_CHARS = 4;
	localparam int TIMEOUT_BITS  = 12;

	// Highest pending source, in priority order
	typedef enum logic [2:0] {
		SRC_NONE = 3'b000,
		SRC_LS   = 3'b001,
		SRC_TO   = 3'b010,
		SRC_RX   = 3'b011,
		SRC_TX   = 3'b100,
		SRC_MS   = 3'b101
	} src_t;

endpackage : uart_irq_pkg

// [verif/host_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
	input  wire logic       sys_clk,
	input  wire logic [7:0] rd_data,
	output var  logic [2:0] addr,
	output var  logic       rd_en,
	output var  logic       wr_en,
	output var  logic [7:0] wr_data
);
	initial begin
		addr    = 3'h0;
		rd_en   = 1'b0;
		wr_en   = 1'b0;
		wr_data = 8'h00;
	end

	// Strobe held across one sampling edge; an idle edge follows so strobes never merge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr    <= a;
		wr_data <= d;
		wr_en   <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		#1;
	endtask : wr

	// Data is registered at the strobe edge and taken one edge later
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		@(posedge sys_clk);
		d = rd_data;
		#1;
	endtask : rd
endmodule : host_bus_model

`default_nettype wire

// [verif/uart_interrupt_fifo_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module uart_interrupt_fifo_control_test
	import uart_irq_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [2:0]  addr;
	logic        rd_en, wr_en;
	logic [7:0]  wr_data, rd_data, d;
	logic [4:0]  rx_fifo_count = 5'h00, rx_trigger_level;
	logic        rx_char_loaded = 1'b0, rx_overrun_evt = 1'b0, rx_fifo_any_error = 1'b0;
	logic        rx_bit_tick = 1'b0, tx_holding_empty = 1'b0, tx_all_empty = 1'b0;
	logic        tx_fifo_full = 1'b0;
	logic [2:0]  rx_head_error = 3'h0;
	logic [3:0]  char_bits = 4'hA, modem_lines = 4'h0, modem_change = 4'h0;
	logic        fifo_enabled, dma_mode, rx_fifo_reset, tx_fifo_reset, irq;
	logic        receive_ready_pin_n, transmit_ready_pin_n;
	logic [31:0] seed = 32'hE9EB8B47;
	int          n_fail = 0;
	int          total_checks = 0;

	always #2 sys_clk = ~sys_clk;

	host_bus_model host (.sys_clk, .rd_data, .addr, .rd_en, .wr_en, .wr_data);

	uart_interrupt_fifo_control DUT (
		.sys_clk, .rst, .addr, .rd_en, .wr_en, .wr_data, .rd_data, .divisor_sel(1'b0),
		.rx_fifo_count, .rx_char_loaded, .rx_overrun_evt, .rx_head_error, .rx_fifo_any_error,
		.rx_bit_tick, .char_bits, .tx_holding_empty, .tx_all_empty, .tx_fifo_full,
		.modem_lines, .modem_change, .fifo_enabled, .dma_mode, .rx_trigger_level,
		.rx_fifo_reset, .tx_fifo_reset, .receive_ready_pin_n, .transmit_ready_pin_n, .irq
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [4:0] trig_of(input logic [1:0] c);
		return c[1] ? (c[0] ? TRIG_LVL3 : TRIG_LVL2) : (c[0] ? TRIG_LVL1 : TRIG_LVL0);
	endfunction : trig_of

	task automatic chk_rd(input logic [2:0] a, input logic [7:0] e, input string nm);
		logic [7:0] v;
		host.rd(a, v);
		`CHK(nm, e, v)
	endtask : chk_rd

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	// Cuts a hang short; the sequence below needs far fewer cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		give_verdict();
	end

	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		chk_rd(ADDR_IE, 8'h00, "ie reset");
		chk_rd(ADDR_IS, 8'h01, "is reset");
		`CHK("trig reset", TRIG_LVL0, rx_trigger_level)
		// Every trigger code, with random DMA and flush bits riding along
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			host.wr(ADDR_IS, {i[1:0], 2'b00, seed[3:1], 1'b1});
			`CHK("trig", trig_of(i[1:0]), rx_trigger_level)
			`CHK("dma", seed[3], dma_mode)
			chk_rd(ADDR_IS, 8'hC1, "is fifo on");
		end
		seed = lfsr(seed);
		host.wr(ADDR_IS, {seed[7:1], 1'b0});
		`CHK("fifo off", 1'b0, fifo_enabled)
		`CHK("trig kept", TRIG_LVL3, rx_trigger_level)
		chk_rd(ADDR_IS, 8'h01, "is fifo off");
		host.wr(ADDR_IE, seed[15:8]);
		chk_rd(ADDR_IE, {4'h0, seed[11:8]}, "ie");
		host.wr(ADDR_IE, 8'h00);
		// Polled mode: status moves while irq stays quiet
		host.wr(ADDR_IS, 8'h41);
		@(posedge sys_clk);
		tx_holding_empty  <= 1'b1;
		tx_all_empty      <= 1'b1;
		rx_fifo_any_error <= 1'b1;
		rx_fifo_count     <= 5'h01;
		rx_char_loaded    <= 1'b1;
		modem_change      <= 4'h2;
		modem_lines       <= seed[19:16];
		@(posedge sys_clk);
		rx_char_loaded <= 1'b0;
		modem_change   <= 4'h0;
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK("polled irq", 1'b0, irq)
		chk_rd(ADDR_IS, 8'hC1, "polled is");
		host.rd(ADDR_LS, d);
		`CHK("ls", 8'hE1, d & 8'hE1)
		// All enabled: one source reported at a time, in priority order
		host.wr(ADDR_IE, 8'h0F);
		chk_rd(ADDR_IS, 8'hC2, "tx at enable");
		chk_rd(ADDR_IS, 8'hC0, "ms queued");
		@(posedge sys_clk);
		rx_fifo_count <= 5'h04;
		chk_rd(ADDR_IS, 8'hC4, "rx trig");
		@(posedge sys_clk);
		rx_overrun_evt <= 1'b1;
		@(posedge sys_clk);
		rx_overrun_evt <= 1'b0;
		chk_rd(ADDR_IS, 8'hC6, "ls top");
		host.rd(ADDR_LS, d);
		`CHK("ls overrun", 8'hE3, d)
		chk_rd(ADDR_IS, 8'hC4, "ls cleared");
		@(posedge sys_clk);
		rx_fifo_count <= 5'h03;
		chk_rd(ADDR_IS, 8'hC0, "below trig");
		chk_rd(ADDR_MS, {seed[19:16], 4'h2}, "ms");
		chk_rd(ADDR_IS, 8'hC1, "ms cleared");
		`CHK("irq idle", 1'b0, irq)
		// Timeout: four 10-bit frames plus 12 bits is 52 ticks, one tick a cycle
		host.wr(ADDR_IE, 8'h01);
		@(posedge sys_clk);
		rx_fifo_count  <= 5'h01;
		rx_char_loaded <= 1'b1;
		@(posedge sys_clk);
		rx_char_loaded <= 1'b0;
		rx_bit_tick    <= 1'b1;
		repeat (40) @(posedge sys_clk);
		chk_rd(ADDR_IS, 8'hC1, "to early");
		`CHK("rx pin", 1'b0, receive_ready_pin_n)
		`CHK("tx pin", 1'b0, transmit_ready_pin_n)
		repeat (20) @(posedge sys_clk);
		chk_rd(ADDR_IS, 8'hCC, "to fired");
		host.rd(ADDR_DATA, d);
		chk_rd(ADDR_IS, 8'hC1, "to cleared");
		// DMA select: transmit pin now follows FIFO full
		host.wr(ADDR_IS, 8'h49);
		@(posedge sys_clk);
		tx_fifo_full <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK("dma tx pin", 1'b1, transmit_ready_pin_n)
		give_verdict();
	end
endmodule : uart_interrupt_fifo_control_test

`default_nettype wire

// [verif/uart_irq_checker.sv]
`timescale 1ns/1ps
`default_nettype none

module uart_irq_checker
	import uart_irq_pkg::*;
#(
	parameter int CNT_W = 5
) (
	input wire logic             sys_clk,
	input wire logic             rst,
	input wire logic [2:0]       addr,
	input wire logic             rd_en,
	input wire logic             wr_en,
	input wire logic [7:0]       wr_data,
	input wire logic [7:0]       rd_data,
	input wire logic             divisor_sel,
	input wire logic [CNT_W-1:0] rx_fifo_count,
	input wire logic             fifo_enabled,
	input wire logic             dma_mode,
	input wire logic [4:0]       rx_trigger_level,
	input wire logic             rx_fifo_reset,
	input wire logic             tx_fifo_reset,
	input wire logic             receive_ready_pin_n,
	input wire logic             irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	logic [4:0] trig_r;
	logic       ie_off_r;

	// Shadow of what the host programmed; a write without the enable bit leaves the level alone
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			trig_r   <= TRIG_LVL0;
			ie_off_r <= 1'b1;
		end else begin
			if (wr_en && addr == ADDR_IS && wr_data[FC_EN])
				trig_r <= wr_data[7] ? (wr_data[6] ? TRIG_LVL3 : TRIG_LVL2)
					: (wr_data[6] ? TRIG_LVL1 : TRIG_LVL0);
			if (wr_en && addr == ADDR_IE && !divisor_sel)
				ie_off_r <= (wr_data[3:0] == 4'h0);
		end
	end

	sequence s_fc_wr;
		wr_en && addr == ADDR_IS;
	endsequence
	sequence s_is_rd;
		rd_en && addr == ADDR_IS;
	endsequence

	a_trig_level: assert property (rx_trigger_level == trig_r)
		else $error("trigger level differs from programmed code");
	a_fc_enable: assert property (s_fc_wr |=> fifo_enabled == $past(wr_data[FC_EN]))
		else $error("fifo enable not taken from write");
	a_dma_select: assert property (s_fc_wr ##0 wr_data[FC_EN] |=> dma_mode == $past(wr_data[FC_DMA]))
		else $error("dma mode not taken from write");
	a_rx_flush_pulse: assert property (s_fc_wr ##1 !wr_en |->
		rx_fifo_reset == ($past(wr_data[FC_EN]) && $past(wr_data[FC_RXRST]))
		##1 !rx_fifo_reset)
		else $error("receive flush pulse wrong");
	a_tx_flush_pulse: assert property (s_fc_wr ##1 !wr_en |->
		tx_fifo_reset == ($past(wr_data[FC_EN]) && $past(wr_data[FC_TXRST]))
		##1 !tx_fifo_reset)
		else $error("transmit flush pulse wrong");
	a_ie_upper_zero: assert property (rd_en && addr == ADDR_IE && !divisor_sel |=> rd_data[7:4] == 4'h0)
		else $error("enable upper nibble not zero");
	a_is_layout: assert property (s_is_rd |=> rd_data[5:4] == 2'h0 && rd_data[7:6] == {2{$past(fifo_enabled)}})
		else $error("status top bits wrong");
	a_is_pending: assert property (s_is_rd |=> rd_data[0] == !$past(irq))
		else $error("status bit zero disagrees with irq");
	a_is_none_code: assert property (s_is_rd ##0 !irq |=> rd_data[3:0] == IS_NONE)
		else $error("idle status code wrong");
	a_polled_quiet: assert property (ie_off_r |-> !irq)
		else $error("irq raised with all enables clear");
	a_ready_pin: assert property ((!dma_mode && rx_fifo_count != '0) [*2] |-> !receive_ready_pin_n)
		else $error("receive ready pin idle with data held");
endmodule : uart_irq_checker

bind uart_interrupt_fifo_control uart_irq_checker #(.CNT_W(CNT_W)) chk (
	.sys_clk, .rst, .addr, .rd_en, .wr_en, .wr_data, .rd_data, .divisor_sel, .rx_fifo_count,
	.fifo_enabled, .dma_mode, .rx_trigger_level, .rx_fifo_reset, .tx_fifo_reset,
	.receive_ready_pin_n, .irq
);

`default_nettype wire
